// ===== scc_pkg.sv
package scc_pkg;
    // ==========================================
    // Register map
    // ==========================================
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam logic [11:0] ADDR_FINE_EN    = 12'h117;
    localparam logic [11:0] ADDR_FINE_SKEW  = 12'h118;
    localparam logic [11:0] ADDR_CLK_STAT   = 12'h11C;
    localparam logic [11:0] ADDR_SYNC_A     = 12'h120;
    localparam logic [11:0] ADDR_SYNC_B     = 12'h121;
    localparam logic [11:0] ADDR_WIN_STAT   = 12'h128;
    localparam logic [11:0] ADDR_PHASE_STAT = 12'h129;
    localparam logic [11:0] ADDR_TALLY      = 12'h12A;
    localparam logic [7:0]  RST_FINE_EN     = 8'h00;
    localparam logic [7:0]  RST_FINE_SKEW   = 8'h00;
    localparam logic [7:0]  RST_SYNC_A      = 8'h00;
    localparam logic [7:0]  RST_SYNC_B      = 8'h00;
    localparam logic [7:0]  RST_WIN_STAT    = 8'h00;
    localparam logic [3:0]  RST_PHASE       = 4'h0;
    localparam logic [7:0]  RST_TALLY       = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED     = 8'h00;
    // ==========================================
    // Field positions
    // ==========================================
    localparam int FINE_EN_BIT = 0;
    localparam int CLK_OK_BIT  = 0;
    localparam int TRANS_BIT   = 4;
    localparam int EDGE_BIT    = 3;
    localparam int MODE_LSB    = 1;
    localparam int IGN_LSB     = 0;
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_CONT  = 2'h1;
    localparam logic [1:0] MODE_NSHOT = 2'h2;
    // ==========================================
    // Fine skew and counts
    // ==========================================
    localparam logic signed [7:0] SKEW_MIN     = 8'shA8;
    localparam logic signed [7:0] SKEW_MAX     = 8'sh57;
    localparam int                SKEW_STEP_FS = 1700;
    localparam logic [3:0]        IGN_MAX_CODE = 4'hF;
    localparam logic [4:0]        IGN_MAX_SKIP = 5'h10;
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int CLK_TIMEOUT_NS  = 1000;
    localparam int CLK_TIMEOUT_CYC = (CLK_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [7:0] CLK_TIMEOUT_CNT = CLK_TIMEOUT_CYC[7:0];

    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_SKIP, ST_DONE} scc_state_t;
endpackage

// ===== scc_sync_detect.sv
`timescale 1ns/1ps
module scc_sync_detect
    import scc_pkg::*;
(
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    scc_sync_if.detect   sif
);
    logic prev_clk;
    logic sampled;
    logic primed;
    logic clk_edge;
    logic sync_event;
    logic next_prev_clk;
    logic next_sampled;
    logic next_primed;
    logic next_clk_edge;
    logic next_sync_event;
    logic rise;
    logic fall;
    logic sample_now;

    // ==========================================
    // Edge pick and transition qualify
    // ==========================================
    always_comb begin
        rise            = sif.clk_in & ~prev_clk;
        fall            = ~sif.clk_in & prev_clk;
        sample_now      = sif.edge_sel ? fall : rise;  // R5
        next_prev_clk   = sif.clk_in;
        next_clk_edge   = rise | fall;
        next_sampled    = sampled;
        next_primed     = primed;
        next_sync_event = 1'b0;
        if (sample_now) begin
            next_sampled = sif.sync_in;
            next_primed  = 1'b1;
            // First sample only primes, so a high line at reset is no event
            if (primed) begin
                next_sync_event = sif.trans_sel ? (sampled & ~sif.sync_in)
                                                : (~sampled & sif.sync_in);  // R4
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            prev_clk   <= 1'b0;
            sampled    <= 1'b0;
            primed     <= 1'b0;
            clk_edge   <= 1'b0;
            sync_event <= 1'b0;
        end else begin
            prev_clk   <= next_prev_clk;
            sampled    <= next_sampled;
            primed     <= next_primed;
            clk_edge   <= next_clk_edge;
            sync_event <= next_sync_event;
        end
    end

    assign sif.clk_edge   = clk_edge;
    assign sif.sync_event = sync_event;
endmodule

// ===== scc_sync_if.sv
`timescale 1ns/1ps
interface scc_sync_if;
    logic clk_in;
    logic sync_in;
    logic edge_sel;
    logic trans_sel;
    logic clk_edge;
    logic sync_event;

    modport detect (input clk_in, input sync_in, input edge_sel, input trans_sel,
                    output clk_edge, output sync_event);
    modport ctrl   (output clk_in, output sync_in, output edge_sel, output trans_sel,
                    input clk_edge, input sync_event);
endinterface

// ===== scc_sync_src.sv
`timescale 1ns/1ps
module scc_sync_src (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_run,
    input  wire logic [2:0] i_period,
    output logic            o_clk_in,
    output logic            o_sync
);
    // ====================
    // Source timing
    // ====================
    // Parks only after a falling edge, so each sync change is seen by both edges
    logic [1:0] ph;
    logic [2:0] per;
    logic       busy;
    assign busy = i_run || o_clk_in || ph != 2'h0;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ph       <= 2'h0;
            per      <= 3'h0;
            o_clk_in <= 1'b0;
            o_sync   <= 1'b0;
        end else if (busy) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
                o_clk_in <= !o_clk_in;
            end
            // Sync moves mid-low, two ticks clear of either edge
            if (ph == 2'h1 && !o_clk_in) begin
                per    <= (per + 3'h1 == i_period) ? 3'h0 : per + 3'h1;
                o_sync <= (per + 3'h1 == i_period) ? !o_sync : o_sync;
            end
        end
    end
endmodule

// ===== scc_top.sv
// How it works
// R1 - The fine skew code is signed and clamps to -88 and +87, each step about 1.7 ps.
// R2 - The skew reaches the clock only while the enable bit is set, and setting it pulses a data-path soft reset.
// R3 - A read-only bit shows 1 while an input clock toggles and 0 when none is seen.
// R4 - A sync event is a low-to-high sample change when transition select is 0, high-to-low when it is 1.
// R5 - Sync is sampled on the input clock rising edge when edge select is 0, falling edge when 1.
// R6 - Mode 00 disables capture, 01 captures every event, 10 runs N-shot.
// R7 - N-shot with ignore code 0000 acts on the next event only and then goes deaf.
// R8 - N-shot skips one leading event at 0001 up to sixteen at 1111 before acting on one.
// R9 - The host selects N-shot mode before the ignore count has any meaning.
// R10 - The divider phase at each capture is kept in a read-only field, 0000 meaning in phase.
// R11 - That phase counts half input-clock cycles, up to seven and a half.
// R12 - An eight-bit read-only tally counts captures and wraps to zero.
`timescale 1ns/1ps
module scc_top
    import scc_pkg::*;
(
    input  wire logic              I_CLK,
    input  wire logic              I_RST_N,
    input  wire logic [ADDR_W-1:0] I_REG_ADDR,
    input  wire logic [DATA_W-1:0] I_REG_WDATA,
    input  wire logic              I_REG_WR,
    input  wire logic              I_REG_RD,
    output logic      [DATA_W-1:0] O_REG_RDATA,
    input  wire logic              I_CLK_IN,
    input  wire logic              I_SYNC,
    output logic signed [7:0]      O_FINE_SKEW,
    output logic                   O_SOFT_RST,
    output logic                   O_RESYNC,
    output logic                   O_CLK_PRESENT
);
    // ==========================================
    // Register file
    // ==========================================
    logic [7:0] fine_en_reg;
    logic [7:0] skew_reg;
    logic [7:0] setup_a;
    logic [7:0] setup_b;
    logic [7:0] rdata;
    logic       soft_rst;
    logic       rearm;
    logic [7:0] next_fine_en_reg;
    logic [7:0] next_skew_reg;
    logic [7:0] next_setup_a;
    logic [7:0] next_setup_b;
    logic [7:0] next_rdata;
    logic       next_soft_rst;
    logic       next_rearm;

    logic [3:0] phase_cap;
    logic [7:0] tally;
    logic       clk_ok;

    always_comb begin
        next_fine_en_reg = fine_en_reg;
        next_skew_reg    = skew_reg;
        next_setup_a     = setup_a;
        next_setup_b     = setup_b;
        next_soft_rst    = 1'b0;
        next_rearm       = 1'b0;
        next_rdata       = rdata;
        if (I_REG_WR) begin
            case (I_REG_ADDR)
                ADDR_FINE_EN: begin
                    next_fine_en_reg = {7'h00, I_REG_WDATA[FINE_EN_BIT]};
                    next_soft_rst    = I_REG_WDATA[FINE_EN_BIT] & ~fine_en_reg[FINE_EN_BIT];  // R2
                end
                ADDR_FINE_SKEW: begin
                    next_skew_reg = I_REG_WDATA;
                end
                ADDR_SYNC_A: begin
                    next_setup_a = {3'h0, I_REG_WDATA[4:0]};
                    next_rearm   = 1'b1;
                end
                ADDR_SYNC_B: begin
                    next_setup_b = {4'h0, I_REG_WDATA[3:0]};
                    next_rearm   = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (I_REG_RD) begin
            case (I_REG_ADDR)
                ADDR_FINE_EN:    next_rdata = fine_en_reg;
                ADDR_FINE_SKEW:  next_rdata = skew_reg;
                ADDR_CLK_STAT:   next_rdata = {7'h00, clk_ok};  // R3
                ADDR_SYNC_A:     next_rdata = setup_a;
                ADDR_SYNC_B:     next_rdata = setup_b;
                ADDR_WIN_STAT:   next_rdata = RST_WIN_STAT;
                ADDR_PHASE_STAT: next_rdata = {4'h0, phase_cap};  // R10
                ADDR_TALLY:      next_rdata = tally;  // R12
                default:         next_rdata = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            fine_en_reg <= RST_FINE_EN;
            skew_reg    <= RST_FINE_SKEW;
            setup_a     <= RST_SYNC_A;
            setup_b     <= RST_SYNC_B;
            rdata       <= RD_UNMAPPED;
            soft_rst    <= 1'b0;
            rearm       <= 1'b0;
        end else begin
            fine_en_reg <= next_fine_en_reg;
            skew_reg    <= next_skew_reg;
            setup_a     <= next_setup_a;
            setup_b     <= next_setup_b;
            rdata       <= next_rdata;
            soft_rst    <= next_soft_rst;
            rearm       <= next_rearm;
        end
    end

    // ==========================================
    // Fine skew trim
    // ==========================================
    logic signed [7:0] skew_code;
    logic signed [7:0] skew_out;
    logic signed [7:0] next_skew_out;

    always_comb begin
        skew_code = signed'(skew_reg);
        if (skew_code <= SKEW_MIN) begin
            next_skew_out = SKEW_MIN;  // R1
        end else if (skew_code >= SKEW_MAX) begin
            next_skew_out = SKEW_MAX;  // R1
        end else begin
            next_skew_out = skew_code;
        end
        if (!fine_en_reg[FINE_EN_BIT]) begin
            next_skew_out = 8'sh00;  // R2
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            skew_out <= 8'sh00;
        end else begin
            skew_out <= next_skew_out;
        end
    end

    // ==========================================
    // Sync edge detection
    // ==========================================
    scc_sync_if sif ();

    assign sif.clk_in    = I_CLK_IN;
    assign sif.sync_in   = I_SYNC;
    assign sif.edge_sel  = setup_a[EDGE_BIT];
    assign sif.trans_sel = setup_a[TRANS_BIT];

    scc_sync_detect u_detect (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .sif     (sif)
    );

    // ==========================================
    // Clock presence watchdog
    // ==========================================
    logic [7:0] idle_cnt;
    logic [7:0] next_idle_cnt;
    logic       next_clk_ok;

    always_comb begin
        next_idle_cnt = idle_cnt;
        next_clk_ok   = clk_ok;
        if (sif.clk_edge) begin
            next_idle_cnt = 8'h00;
            next_clk_ok   = 1'b1;  // R3
        end else if (idle_cnt == CLK_TIMEOUT_CNT) begin
            next_clk_ok   = 1'b0;  // R3
        end else begin
            next_idle_cnt = idle_cnt + 8'h01;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            idle_cnt <= 8'h00;
            clk_ok   <= 1'b0;
        end else begin
            idle_cnt <= next_idle_cnt;
            clk_ok   <= next_clk_ok;
        end
    end

    // ==========================================
    // Capture sequencer, divider phase, tally
    // ==========================================
    scc_state_t state;
    scc_state_t next_state;
    logic [4:0] skip_left;
    logic [4:0] next_skip_left;
    logic [3:0] div_phase;
    logic [3:0] next_div_phase;
    logic [3:0] next_phase_cap;
    logic [7:0] next_tally;
    logic       resync;
    logic       next_resync;
    logic       act;
    logic [1:0] mode;
    logic [3:0] ign;

    always_comb begin
        mode           = setup_a[MODE_LSB +: 2];
        ign            = setup_b[IGN_LSB +: 4];
        next_state     = state;
        next_skip_left = skip_left;
        next_phase_cap = phase_cap;
        next_tally     = tally;
        act            = 1'b0;
        // Half-cycle steps: every input clock edge moves the divider by one
        next_div_phase = sif.clk_edge ? div_phase + 4'h1 : div_phase;  // R11
        if (rearm) begin
            // Events in the rearm cycle are dropped for a clean start
            case (mode)
                MODE_CONT:  next_state = ST_RUN;  // R6
                MODE_NSHOT: next_state = ST_SKIP;  // R6 R9
                default:    next_state = ST_OFF;  // R6
            endcase
            next_skip_left = (ign == IGN_MAX_CODE) ? IGN_MAX_SKIP : {1'b0, ign};  // R8
        end else if (sif.sync_event) begin
            case (state)
                ST_RUN: begin
                    act = 1'b1;  // R6
                end
                ST_SKIP: begin
                    if (skip_left == 5'h00) begin
                        act        = 1'b1;  // R7
                        next_state = ST_DONE;  // R7
                    end else begin
                        next_skip_left = skip_left - 5'h01;  // R8
                    end
                end
                ST_OFF, ST_DONE: begin
                end
                default: begin
                    next_state = ST_OFF;
                end
            endcase
        end
        if (act) begin
            // The capturing edge is itself one half-cycle step
            next_phase_cap = div_phase + 4'h1;  // R10 R11
            next_tally     = tally + 8'h01;  // R12
            next_div_phase = 4'h0;
        end
        next_resync = act;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state     <= ST_OFF;
            skip_left <= 5'h00;
            div_phase <= 4'h0;
            phase_cap <= RST_PHASE;
            tally     <= RST_TALLY;
            resync    <= 1'b0;
        end else begin
            state     <= next_state;
            skip_left <= next_skip_left;
            div_phase <= next_div_phase;
            phase_cap <= next_phase_cap;
            tally     <= next_tally;
            resync    <= next_resync;
        end
    end

    // ==========================================
    // Elaboration checks
    // ==========================================
    // Watchdog counter is only eight bits wide
    if (CLK_TIMEOUT_CYC < 1 || CLK_TIMEOUT_CYC > 255) begin : g_bad_timeout
        $error("clock watchdog count does not fit its counter");
    end
    // Top ignore code must skip one more than its value
    if (IGN_MAX_SKIP != {1'b0, IGN_MAX_CODE} + 5'h01) begin : g_bad_skip
        $error("largest skip does not follow the top ignore code");
    end
    if (SKEW_MIN >= SKEW_MAX) begin : g_bad_clamp
        $error("skew clamp bounds reversed");
    end
    // Setup fields must stay inside one byte
    if (TRANS_BIT > 7 || EDGE_BIT > 7 || MODE_LSB > 6 || IGN_LSB > 4) begin : g_bad_field
        $error("sync setup fields fall outside the register");
    end
    if (ADDR_W != 12 || DATA_W != 8) begin : g_bad_bus
        $error("register bus widths differ from the map");
    end

    assign O_REG_RDATA   = rdata;
    assign O_FINE_SKEW   = skew_out;
    assign O_SOFT_RST    = soft_rst;
    assign O_RESYNC      = resync;
    assign O_CLK_PRESENT = clk_ok;
endmodule

// ===== scc_top_sva.sv
`timescale 1ns/1ps
module scc_top_sva
    import scc_pkg::*;
(
    input wire logic              I_CLK,
    input wire logic              I_RST_N,
    input wire logic [ADDR_W-1:0] I_REG_ADDR,
    input wire logic [DATA_W-1:0] I_REG_WDATA,
    input wire logic              I_REG_WR,
    input wire logic              I_REG_RD,
    input wire logic [DATA_W-1:0] O_REG_RDATA,
    input wire logic              I_CLK_IN,
    input wire logic              I_SYNC,
    input wire logic signed [7:0] O_FINE_SKEW,
    input wire logic              O_SOFT_RST,
    input wire logic              O_RESYNC,
    input wire logic              O_CLK_PRESENT
);
    // ====================
    // Shadow state
    // ====================
    logic       cfg_wr;
    logic       clk_q;
    logic       next_clk_q;
    logic [7:0] idle;
    logic [7:0] next_idle;
    logic [1:0] mode;
    logic [1:0] next_mode;
    logic [1:0] shots;
    logic [1:0] next_shots;
    logic [7:0] tally;
    logic [7:0] next_tally;
    assign cfg_wr = I_REG_WR && (I_REG_ADDR == ADDR_SYNC_A || I_REG_ADDR == ADDR_SYNC_B);
    always_comb begin
        next_clk_q = I_CLK_IN;
        next_idle  = (I_CLK_IN != clk_q) ? 8'h00 : idle + {7'h00, idle != 8'hFF};
        next_mode  = (I_REG_WR && I_REG_ADDR == ADDR_SYNC_A) ? I_REG_WDATA[MODE_LSB +: 2] : mode;
        next_shots = cfg_wr ? 2'h0 : shots + {1'b0, O_RESYNC && shots != 2'h3};
        next_tally = tally + {7'h00, O_RESYNC};
    end
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            clk_q <= 1'b0;
            idle  <= 8'h00;
            mode  <= MODE_OFF;
            shots <= 2'h0;
            tally <= 8'h00;
        end else begin
            clk_q <= next_clk_q;
            idle  <= next_idle;
            mode  <= next_mode;
            shots <= next_shots;
            tally <= next_tally;
        end
    end
    // ====================
    // Checks
    // ====================
    default clocking dcb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    resync_width_a: assert property (O_RESYNC |=> !O_RESYNC)
        else $error("resync pulse longer than one cycle");
    soft_rst_cause_a: assert property (O_SOFT_RST |-> $past(I_REG_WR) && $past(I_REG_ADDR) == ADDR_FINE_EN
        && $past(I_REG_WDATA[FINE_EN_BIT])) else $error("soft reset without enable write");
    soft_rst_width_a: assert property (O_SOFT_RST |=> !O_SOFT_RST)
        else $error("soft reset longer than one cycle");
    skew_range_a: assert property (O_FINE_SKEW >= SKEW_MIN && O_FINE_SKEW <= SKEW_MAX)
        else $error("applied skew outside clamp");
    skew_cause_a: assert property ($changed(O_FINE_SKEW) |-> $past(I_REG_WR) || $past(I_REG_WR, 2))
        else $error("applied skew moved without a write");
    clk_seen_a: assert property ($past(I_RST_N) && $changed(I_CLK_IN) |-> ##2 O_CLK_PRESENT)
        else $error("clock toggle not reported");
    clk_lost_a: assert property (idle >= 8'hD2 |-> !O_CLK_PRESENT)
        else $error("clock presence kept without toggles");
    capture_edge_a: assert property (O_RESYNC |-> $past(I_CLK_IN, 2) != $past(I_CLK_IN, 3))
        else $error("capture without an input clock edge");
    capture_off_a: assert property (I_REG_WR && I_REG_ADDR == ADDR_SYNC_A
        && I_REG_WDATA[2] == I_REG_WDATA[1] ##1 !I_REG_WR [*3] |-> !O_RESYNC) else $error("capture while off");
    nshot_once_a: assert property (mode == MODE_NSHOT |-> shots <= 2'h1)
        else $error("second capture in single-shot mode");
    tally_read_a: assert property ($past(I_REG_RD) && $past(I_REG_ADDR) == ADDR_TALLY
        |-> O_REG_RDATA == $past(tally) + {7'h00, $past(O_RESYNC)}) else $error("tally read mismatch");
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench
    import scc_pkg::*;
;
    logic              I_CLK;
    logic              I_RST_N;
    logic [ADDR_W-1:0] I_REG_ADDR;
    logic [DATA_W-1:0] I_REG_WDATA;
    logic              I_REG_WR;
    logic              I_REG_RD;
    logic [DATA_W-1:0] O_REG_RDATA;
    logic signed [7:0] O_FINE_SKEW;
    logic              O_SOFT_RST;
    logic              O_RESYNC;
    logic              O_CLK_PRESENT;
    logic              clk_in;
    logic              sync;
    logic              run;
    logic              sync_q;
    logic              fall_tr;
    logic              fall_ed;
    logic [7:0]        rq;
    logic [7:0]        t_exp;
    int                err_total;
    int                samples_checked;
    int                pulses;
    int                hits;
    int                first_hits;
    logic [11:0]       ra [9] = '{ADDR_FINE_EN, ADDR_FINE_SKEW, ADDR_CLK_STAT, ADDR_SYNC_A, ADDR_SYNC_B,
                                  ADDR_WIN_STAT, ADDR_PHASE_STAT, ADDR_TALLY, 12'h3FF};
    logic [11:0]       ro [3] = '{ADDR_CLK_STAT, ADDR_PHASE_STAT, ADDR_TALLY};
    logic [7:0]        sk [7] = '{8'h80, 8'hA8, 8'hA9, 8'h00, 8'h56, 8'h57, 8'h7F};
    logic signed [7:0] sx [7] = '{8'shA8, 8'shA8, 8'shA9, 8'sh00, 8'sh56, 8'sh57, 8'sh57};

    scc_sync_src u_src (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_run(run), .i_period(3'h2),
                        .o_clk_in(clk_in), .o_sync(sync));
    scc_top u_dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
                   .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .I_CLK_IN(clk_in),
                   .I_SYNC(sync), .O_FINE_SKEW(O_FINE_SKEW), .O_SOFT_RST(O_SOFT_RST), .O_RESYNC(O_RESYNC),
                   .O_CLK_PRESENT(O_CLK_PRESENT));

    initial begin
        I_CLK = 1'b0;
        forever #2.5 I_CLK = ~I_CLK;
    end
    // ====================
    // Access and checking
    // ====================
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        err_total++;
        $display("[FAIL] %0t ns %s", $time, m);
    endtask
    task automatic ok(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) fail(m);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        I_REG_ADDR  <= a;
        I_REG_WDATA <= d;
        I_REG_WR    <= 1'b1;
        @(posedge I_CLK);
        I_REG_WR    <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string m);
        @(posedge I_CLK);
        I_REG_ADDR <= a;
        I_REG_RD   <= 1'b1;
        @(posedge I_CLK);
        I_REG_RD   <= 1'b0;
        @(negedge I_CLK);
        rq = O_REG_RDATA;
        ok(rq === e, m);
    endtask
    // Counts sync moves in the selected direction and checks each capture
    always @(negedge I_CLK) begin
        if (sync !== sync_q && sync === !fall_tr) hits++;
        sync_q = sync;
        if (O_RESYNC === 1'b1) begin
            if (pulses == 0) first_hits = hits;
            pulses++;
            ok(sync === !fall_tr && clk_in === !fall_ed, "capture direction or edge");
        end
    end
    task automatic scen(input logic [7:0] a, input logic [3:0] b, input int lim);
        int         want;
        rchk(ADDR_TALLY, t_exp, "tally");
        fall_tr = a[TRANS_BIT];
        fall_ed = a[EDGE_BIT];
        wr(ADDR_SYNC_B, {4'h0, b});
        wr(ADDR_SYNC_A, a);
        pulses = 0;
        hits = 0;
        @(posedge I_CLK);
        run <= 1'b1;
        repeat (lim) @(posedge I_CLK);
        run <= 1'b0;
        repeat (24) @(posedge I_CLK);
        want = (a[2:1] == MODE_CONT) ? hits : int'(a[2:1] == MODE_NSHOT);
        ok(pulses == want && (a[2:1] != MODE_CONT || hits > 2), "capture count");
        if (a[2:1] == MODE_NSHOT) ok(first_hits == ((b == IGN_MAX_CODE) ? 17 : b + 1), "ignored events");
        if (a[2:1] == MODE_CONT) rchk(ADDR_PHASE_STAT, 8'h08, "divider phase");
        t_exp = t_exp + want[7:0];
        rchk(ADDR_TALLY, t_exp, "tally count");
        $display("test done: sync setup %h ignore %h", a, b);
    endtask
    initial begin
        #200000;
        fail("run limit reached");
        complete_run();
    end
    // ====================
    // Main sequence
    // ====================
    initial begin
        I_RST_N = 1'b0;
        I_REG_ADDR = 12'h000;
        I_REG_WDATA = 8'h00;
        I_REG_WR = 1'b0;
        I_REG_RD = 1'b0;
        run = 1'b0;
        {sync_q, fall_tr, fall_ed} = 3'h0;
        t_exp = 8'h00;
        {err_total, samples_checked, pulses, hits, first_hits} = '0;
        repeat (10) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        foreach (ra[i]) rchk(ra[i], 8'h00, "reset value");
        foreach (ro[i]) begin
            wr(ro[i], 8'hFF);
            rchk(ro[i], 8'h00, "read-only written");
        end
        $display("test done: reset and read-only");
        for (int p = 0; p < 2; p++) begin
            foreach (sk[i]) begin
                wr(ADDR_FINE_SKEW, sk[i]);
                rchk(ADDR_FINE_SKEW, sk[i], "skew readback");
                ok(O_FINE_SKEW === (p[0] ? sx[i] : 8'sh00), "applied skew");
            end
            wr(ADDR_FINE_EN, 8'hFF);
            @(negedge I_CLK);
            ok(O_SOFT_RST === !p[0], "soft reset pulse");
            @(negedge I_CLK);
            ok(O_SOFT_RST === 1'b0, "soft reset width");
            rchk(ADDR_FINE_EN, 8'h01, "enable bits");
        end
        wr(ADDR_FINE_EN, 8'h00);
        rchk(ADDR_FINE_EN, 8'h00, "enable cleared");
        ok(O_FINE_SKEW === 8'sh00, "skew removed");
        run <= 1'b1;
        repeat (20) @(posedge I_CLK);
        rchk(ADDR_CLK_STAT, 8'h01, "clock seen");
        run <= 1'b0;
        repeat (230) @(posedge I_CLK);
        ok(O_CLK_PRESENT === 1'b0, "clock lost");
        $display("test done: skew and clock presence");
        scen(8'h00, 4'h0, 400);
        scen(8'h06, 4'h0, 400);
        scen(8'h02, 4'h0, 700);
        scen(8'h1A, 4'h0, 700);
        scen(8'h04, 4'h0, 700);
        scen(8'h14, 4'h2, 700);
        scen(8'h0C, 4'h1, 700);
        scen(8'h04, 4'hE, 700);
        scen(8'h04, 4'hF, 700);
        scen(8'h02, 4'h0, 8400);
        complete_run();
    end
endmodule

bind scc_top scc_top_sva u_sva (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
    .I_CLK_IN(I_CLK_IN), .I_SYNC(I_SYNC), .O_FINE_SKEW(O_FINE_SKEW), .O_SOFT_RST(O_SOFT_RST),
    .O_RESYNC(O_RESYNC), .O_CLK_PRESENT(O_CLK_PRESENT));
